// ===== test_tlcsc_ctrl.sv
// self-checking bench for the cache state controller
`timescale 1ns/1ps
module test_tlcsc_ctrl;
    logic clk_sys_in, rst_in, vld, done, ken_n, wb, hold, rdy, st, cyc_n, uv;
    logic na_n, hp, bus_backoff_request_n, crdy;
    logic [3:0] wt;
    logic [2:0] o1;
    logic [26:0] ln;
    tlcsc_pkg::tlcsc_req_t  req;
    tlcsc_pkg::tlcsc_mesi_t l1, l2;
    tlcsc_pkg::tlcsc_op_t   op;
    tlcsc_pkg::tlcsc_upd_t  upd, u1;
    int bad_count, checks_done, ns, ts, n, i;
    // {wr ic sw ca al pwt pf, ken wb, l1 l2, exp l1 l2, starts}
    logic [19:0] rows [14] = '{20'h08e20, 20'h00401,
        20'h08c29, 20'h08815, 20'h08cf8, 20'h28cec,
        20'h48c01, 20'h4cc39, 20'h4ec16, 20'h48d69,
        20'h4ccb8, 20'h48c49, 20'h48f30, 20'h19c29};
    tlcsc_ctrl tlcsc_ctrl_inst (.clk_sys_in, .rst_in, .req_valid_in(vld),
        .req_in(req), .l1_state_in(l1), .l2_state_in(l2), .bus_done_in(done),
        .cache_enable_input_n_in(ken_n), .writeback_select_input_in(wb),
        .next_address_strobe_n_in(na_n), .address_hold_request_in(hold),
        .bus_backoff_request_n_in(bus_backoff_request_n), .core_ready_in(crdy),
        .hi_prio_in(hp), .req_ready_out(rdy), .bus_start_out(st),
        .bus_op_out(op), .bus_line_out(ln), .cacheable_cycle_n_out(cyc_n),
        .upd_valid_out(uv), .upd_out(upd));
    tlcsc_bus_model tlcsc_bus_model_inst (.clk_sys_in, .rst_in,
        .start_in(st), .wait_in(wt), .done_out(done));
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            bad_count++;
            $display("[FAIL] %0t saw %h want %h", $time, seen, exp);
        end
    endtask
    task automatic wrap_up();
        if (bad_count == 0 && checks_done > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic run(input logic [19:0] x, input int hd,
                       input logic [3:0] sv);
        req = {x[18:12], 27'h0000a4};
        ken_n = ~x[11];
        wb = x[10];
        l1 = tlcsc_pkg::tlcsc_mesi_t'(x[9:8]);
        l2 = tlcsc_pkg::tlcsc_mesi_t'(x[7:6]);
        {hold, hp, bus_backoff_request_n, crdy} = sv;
        vld = 1'b1;
        ns = 0;
        u1 = '0;
        @(posedge clk_sys_in);
        #1 vld = 1'b0;
        for (n = 1; n < 60 && !(n > 1 && rdy); n++) begin
            @(posedge clk_sys_in);
            #1;
            if (n == hd) {hold, hp, bus_backoff_request_n, crdy} = 4'b0011;
            if (st && ns == 0) o1 = {op, cyc_n};
            if (st) ns++;
            if (st) ts = n;
            if (uv && u1 == '0) u1 = upd;
        end
        if (n == 60) chk(32'h0, 32'h1);
        if (n == 60) wrap_up();
        chk(u1, {x[5:2], 27'h0000a4});
        chk(ns, x[1:0]);
        if (x[1:0] != 2'b00) chk(o1, (x[18] && !x[14]) ? 3'b101
            : {2'b01, ~x[15]});
    endtask
    initial begin
        clk_sys_in = 1'b0;
        forever #20 clk_sys_in = ~clk_sys_in;
    end
    initial begin
        {rst_in, vld, hold, ken_n, wb, req, wt} = '0;
        {na_n, bus_backoff_request_n, crdy, hp} = 4'b1110;
        l1 = tlcsc_pkg::MESI_I;
        l2 = tlcsc_pkg::MESI_I;
        bad_count = 0;
        checks_done = 0;
        rst_in = 1'b1;
        repeat (3) @(posedge clk_sys_in);
        #1 rst_in = 1'b0;
        chk({rdy, op, cyc_n, uv}, 5'h12);
        for (i = 0; i < 14; i++) begin
            wt = i[3:0]; // mix prompt and slow bus answers
            run(rows[i], 0, 4'b0011);
        end
        wt = 4'h2;
        // no next address: one idle cycle before the companion burst
        run(20'h09c2a, 0, 4'b0011);
        chk(ts, 7);
        chk(ln, 27'h0000a5);
        chk(upd, {4'ha, 27'h0000a5});
        chk(cyc_n, 1'b0);
        run(20'h09c2a, 8, 4'b1011);
        chk(ts, 9);
        run(20'h09c2a, 8, 4'b0100);
        chk(ts, 9);
        na_n = 1'b0;
        run(20'h09c2a, 0, 4'b0011);
        chk(ts, 6);
        na_n = 1'b1;
        wrap_up();
    end
endmodule // test_tlcsc_ctrl

// ===== tlcsc_bus_model.sv
// bus responder model: ends each started cycle after a chosen wait
`timescale 1ns/1ps
module tlcsc_bus_model (
    input  wire logic       clk_sys_in, // system clock
    input  wire logic       rst_in,     // sync reset, high
    input  wire logic       start_in,   // cycle start pulse
    input  wire logic [3:0] wait_in,    // wait cycles before done
    output logic            done_out    // last transfer pulse
);
    logic [3:0] cnt_ff;
    logic       busy_ff;
    always_ff @(posedge clk_sys_in) begin
        if (rst_in || start_in) begin
            busy_ff <= start_in && !rst_in;
            cnt_ff  <= wait_in;
        end else if (busy_ff && cnt_ff != 4'h0) begin
            cnt_ff <= cnt_ff - 4'h1;
        end else begin
            busy_ff <= 1'b0;
        end
    end
    // done is one cycle only; the wait lets slow memory be modelled
    assign done_out = busy_ff && cnt_ff == 4'h0;
endmodule // tlcsc_bus_model

// ===== tlcsc_ctrl.sv
// two-level cache state controller: access sequencing and bus cycles
`timescale 1ns/1ps
`include "tlcsc_regs.svh"

module tlcsc_ctrl (
    input  wire logic                   clk_sys_in,          // 25 mhz clock
    input  wire logic                   rst_in,              // sync reset
    input  wire logic                   req_valid_in,        // access offered
    input  wire tlcsc_pkg::tlcsc_req_t  req_in,              // access fields
    input  wire tlcsc_pkg::tlcsc_mesi_t l1_state_in,         // l1 tag state
    input  wire tlcsc_pkg::tlcsc_mesi_t l2_state_in,         // l2 tag state
    input  wire logic                   bus_done_in,         // cycle ended
    input  wire logic                   cache_enable_input_n_in, // ken, low
    input  wire logic                   writeback_select_input_in, // wb
    input  wire logic                   next_address_strobe_n_in,  // low
    input  wire logic                   address_hold_request_in,   // hold
    input  wire logic                   bus_backoff_request_n_in,  // low
    input  wire logic                   core_ready_in,       // core ready
    input  wire logic                   hi_prio_in,          // other access
    output logic                        req_ready_out,       // can accept
    output logic                        bus_start_out,       // cycle pulse
    output tlcsc_pkg::tlcsc_op_t        bus_op_out,          // read or write
    output logic [`TLCSC_LINE_AW-1:0]   bus_line_out,        // line address
    output logic                        cacheable_cycle_n_out, // low: fill
    output logic                        upd_valid_out,       // tag write
    output tlcsc_pkg::tlcsc_upd_t       upd_out              // new states
);
    // ------------------------------------------------------------------
    // sequencer states
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_IDLE   = 3'b000,
        ST_DECIDE = 3'b001,
        ST_BUS    = 3'b010,
        ST_POSTWR = 3'b011,
        ST_GAP    = 3'b100,
        ST_PF     = 3'b101
    } tlcsc_state_t;

    tlcsc_state_t           state_ff;
    tlcsc_state_t           nxt_state;
    tlcsc_pkg::tlcsc_req_t  cur_ff;
    tlcsc_pkg::tlcsc_mesi_t l1_ff;
    tlcsc_pkg::tlcsc_mesi_t l2_ff;
    logic                   ken_ff;
    logic                   wbs_ff;
    logic                   na_seen_ff;
    logic                   ready_ff;
    logic                   start_ff;
    tlcsc_pkg::tlcsc_op_t   op_ff;
    logic [`TLCSC_LINE_AW-1:0] line_ff;
    logic                   cyc_n_ff;
    logic                   upd_v_ff;
    tlcsc_pkg::tlcsc_upd_t  upd_ff;

    // ------------------------------------------------------------------
    // sampled fill grant and write policy
    // ------------------------------------------------------------------
    wire                        done_now;
    wire                        ken_now;
    wire                        wb_now;
    wire                        pf_go;
    wire                        pf_start;
    wire                        want_pf;
    wire tlcsc_pkg::tlcsc_plan_t plan;
    wire tlcsc_pkg::tlcsc_mesi_t pf_state;
    wire [`TLCSC_LINE_AW-1:0]   pf_line;
    wire                        accept;

    assign accept   = (state_ff == ST_IDLE) && req_valid_in;
    assign done_now = bus_done_in && (state_ff == ST_BUS ||
                      state_ff == ST_POSTWR || state_ff == ST_PF);
    // a fill is granted only on a cycle we marked cacheable
    assign ken_now  = done_now ? (!cache_enable_input_n_in && !cyc_n_ff)
                               : ken_ff;
    // policy comes from this access only: stable per line
    assign wb_now   = done_now ? (writeback_select_input_in && !cur_ff.page_writethrough_attr)
                               : wbs_ff;
    assign pf_state = ken_now ? (wb_now ? tlcsc_pkg::MESI_E
                                        : tlcsc_pkg::MESI_S)
                              : tlcsc_pkg::MESI_I;
    assign pf_line  = cur_ff.line ^ `TLCSC_LINE_AW'(1 << `TLCSC_SECTOR_BIT);
    // hardware prefetch only, and only once the wanted line is in
    assign want_pf  = !cur_ff.write && !cur_ff.sw_prefetch &&
                      cur_ff.hw_pf_en && ken_now &&
                      plan.op == tlcsc_pkg::OP_READ;
    assign pf_start = (state_ff == ST_BUS) && done_now &&
                      !plan.post_wr && want_pf;

    tlcsc_state_table u_table (
        .req_in   (cur_ff),
        .l1_in    (l1_ff),
        .l2_in    (l2_ff),
        .ken_in   (ken_now),
        .wb_in    (wb_now),
        .plan_out (plan)
    );

    tlcsc_pf_gap u_gap (
        .clk_sys_in      (clk_sys_in),
        .rst_in          (rst_in),
        .arm_in          (pf_start),
        .cancel_in       (state_ff != ST_GAP && state_ff != ST_BUS),
        .na_seen_in      (na_seen_ff),
        .core_ready_in   (core_ready_in),
        .hi_prio_in      (hi_prio_in),
        .address_hold_in (address_hold_request_in),
        .backoff_n_in    (bus_backoff_request_n_in),
        .go_out          (pf_go)
    );

    // ------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------
    always_comb begin
        case (state_ff)
            ST_IDLE:   nxt_state = accept ? ST_DECIDE : ST_IDLE;
            ST_DECIDE: nxt_state = (plan.op == tlcsc_pkg::OP_NONE)
                                   ? ST_IDLE : ST_BUS;
            ST_BUS:    nxt_state = !done_now ? ST_BUS :
                                   plan.post_wr ? ST_POSTWR :
                                   want_pf ? ST_GAP : ST_IDLE;
            ST_POSTWR: nxt_state = done_now ? ST_IDLE : ST_POSTWR;
            ST_GAP:    nxt_state = pf_go ? ST_PF : ST_GAP;
            ST_PF:     nxt_state = done_now ? ST_IDLE : ST_PF;
            default:   nxt_state = ST_IDLE;
        endcase
    end

    // ------------------------------------------------------------------
    // state and captured access
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            state_ff   <= ST_IDLE;
            ready_ff   <= `TLCSC_RST_READY;
            ken_ff     <= `TLCSC_RST_KEN;
            wbs_ff     <= `TLCSC_RST_WBS;
            na_seen_ff <= 1'b0;
        end else begin
            state_ff   <= nxt_state;
            ready_ff   <= (nxt_state == ST_IDLE);
            ken_ff     <= ken_now;
            wbs_ff     <= wb_now;
            if (state_ff == ST_DECIDE)
                na_seen_ff <= 1'b0;
            else if (state_ff == ST_BUS && !next_address_strobe_n_in)
                na_seen_ff <= 1'b1;
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            cur_ff <= '0;
            l1_ff  <= tlcsc_pkg::MESI_I;
            l2_ff  <= tlcsc_pkg::MESI_I;
        end else if (accept) begin
            cur_ff <= req_in;
            l1_ff  <= l1_state_in;
            l2_ff  <= l2_state_in;
        end
    end

    // ------------------------------------------------------------------
    // bus cycle request
    // ------------------------------------------------------------------
    wire issue_first;
    wire issue_wr;
    wire issue_pf;

    assign issue_first = (state_ff == ST_DECIDE) &&
                         (plan.op != tlcsc_pkg::OP_NONE);
    // fill first, write through afterwards
    assign issue_wr    = (state_ff == ST_BUS) && done_now && plan.post_wr;
    assign issue_pf    = (state_ff == ST_GAP) && pf_go;

    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            start_ff <= 1'b0;
            op_ff    <= tlcsc_pkg::OP_NONE;
            line_ff  <= '0;
            cyc_n_ff <= 1'b1;
        end else begin
            start_ff <= issue_first || issue_wr || issue_pf;
            if (issue_first) begin
                op_ff    <= plan.op;
                line_ff  <= cur_ff.line;
                cyc_n_ff <= !plan.cacheable;
            end else if (issue_wr) begin
                op_ff    <= tlcsc_pkg::OP_WRITE;
                cyc_n_ff <= 1'b1;
            end else if (issue_pf) begin
                op_ff    <= tlcsc_pkg::OP_READ;
                line_ff  <= pf_line;
                cyc_n_ff <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------
    // tag update
    // ------------------------------------------------------------------
    wire upd_local;
    wire upd_bus;
    wire upd_pf;

    assign upd_local = (state_ff == ST_DECIDE) &&
                       (plan.op == tlcsc_pkg::OP_NONE);
    assign upd_bus   = (state_ff == ST_BUS) && done_now;
    assign upd_pf    = (state_ff == ST_PF) && done_now;

    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            upd_v_ff <= 1'b0;
            upd_ff   <= '{l1: tlcsc_pkg::MESI_I, l2: tlcsc_pkg::MESI_I,
                          line: '0};
        end else begin
            upd_v_ff <= upd_local || upd_bus || upd_pf;
            if (upd_pf)
                upd_ff <= '{l1: pf_state, l2: pf_state, line: pf_line};
            else if (upd_local || upd_bus)
                upd_ff <= '{l1: plan.l1, l2: plan.l2, line: cur_ff.line};
        end
    end

    assign req_ready_out         = ready_ff;
    assign bus_start_out         = start_ff;
    assign bus_op_out            = op_ff;
    assign bus_line_out          = line_ff;
    assign cacheable_cycle_n_out = cyc_n_ff;
    assign upd_valid_out         = upd_v_ff;
    assign upd_out               = upd_ff;

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (rst_in);

    a_pf_companion: assert property (
        issue_pf |=> bus_line_out ==
            (cur_ff.line ^ `TLCSC_LINE_AW'(1 << `TLCSC_SECTOR_BIT)))
        else $error("prefetch burst not on the companion line");
    a_pf_burst: assert property (
        (state_ff == ST_GAP) ##1 (state_ff == ST_PF) |->
            bus_start_out && !cacheable_cycle_n_out &&
            bus_op_out == tlcsc_pkg::OP_READ)
        else $error("prefetch is not a cacheable read");
    a_pf_wait_busy: assert property (
        (state_ff == ST_GAP && (hi_prio_in || !core_ready_in)) |=>
            state_ff == ST_GAP && !bus_start_out)
        else $error("prefetch started while busy");
    a_pf_hold_wait: assert property (
        (state_ff == ST_GAP && (address_hold_request_in ||
            !bus_backoff_request_n_in)) |=> !bus_start_out)
        else $error("prefetch started under hold or back-off");
    a_sw_no_pf: assert property (
        state_ff == ST_GAP |-> !cur_ff.sw_prefetch)
        else $error("software prefetch fetched a companion");
    a_nc_single: assert property (
        (bus_start_out && bus_op_out == tlcsc_pkg::OP_READ &&
            state_ff == ST_BUS && !cur_ff.cacheable) |->
            cacheable_cycle_n_out)
        else $error("uncacheable read marked cacheable");
    a_fill_ken: assert property (
        (upd_bus && plan.op == tlcsc_pkg::OP_READ &&
            plan.l2 != tlcsc_pkg::MESI_I) |->
            !cache_enable_input_n_in && !cacheable_cycle_n_out)
        else $error("line filled without enable");
    a_wb_exclusive: assert property (
        (upd_pf && pf_state == tlcsc_pkg::MESI_E) |->
            writeback_select_input_in && !cur_ff.page_writethrough_attr)
        else $error("exclusive fill in writethrough mode");
    a_no_e_over_m: assert property (
        (upd_valid_out && !cur_ff.icache) |->
            !(upd_out.l1 == tlcsc_pkg::MESI_E &&
              upd_out.l2 == tlcsc_pkg::MESI_M))
        else $error("data l1 exclusive over modified l2");
    a_wr_single: assert property (
        (accept && req_in.write && !req_in.write_alloc &&
            l1_state_in == tlcsc_pkg::MESI_I &&
            l2_state_in == tlcsc_pkg::MESI_I) |=>
            ##1 bus_start_out && bus_op_out == tlcsc_pkg::OP_WRITE)
        else $error("write miss did not issue a single write");
    a_rdhit_nobus: assert property (
        (accept && !req_in.write &&
            l1_state_in != tlcsc_pkg::MESI_I) |=>
            !bus_start_out ##1 (upd_valid_out && !bus_start_out))
        else $error("l1 read hit used the bus");

    c_prefetch: cover property (state_ff == ST_GAP ##[1:20] state_ff == ST_PF);
    c_post_write: cover property (issue_wr);
    c_local_hit: cover property (upd_local);
    c_nc_read: cover property (bus_start_out && cacheable_cycle_n_out &&
                               bus_op_out == tlcsc_pkg::OP_READ);

endmodule // tlcsc_ctrl

// ===== tlcsc_pf_gap.sv
// spacing logic between the two bursts of a sector prefetch
`timescale 1ns/1ps

module tlcsc_pf_gap (
    input  wire logic clk_sys_in,          // system clock
    input  wire logic rst_in,              // sync reset, high
    input  wire logic arm_in,              // first burst finished, pulse
    input  wire logic cancel_in,           // drop a pending prefetch
    input  wire logic na_seen_in,          // next address seen in burst 1
    input  wire logic core_ready_in,       // core can start a cycle
    input  wire logic hi_prio_in,          // other reads or writes pending
    input  wire logic address_hold_in,     // address hold request
    input  wire logic backoff_n_in,        // back-off request, low
    output logic      go_out               // start burst 2 now
);
    logic armed_ff;
    logic na_ok_ff;
    wire  clear_path;

    // ------------------------------------------------------------------
    // issue condition
    // ------------------------------------------------------------------
    assign clear_path = core_ready_in && !hi_prio_in;
    assign go_out     = armed_ff && na_ok_ff && clear_path &&
                        !address_hold_in && backoff_n_in;

    // without next address the second burst waits one idle cycle
    always_ff @(posedge clk_sys_in) begin
        if (rst_in || cancel_in || go_out) begin
            armed_ff <= 1'b0;
            na_ok_ff <= 1'b0;
        end else if (arm_in) begin
            armed_ff <= 1'b1;
            na_ok_ff <= na_seen_in;
        end else if (armed_ff) begin
            na_ok_ff <= 1'b1;
        end
    end

endmodule // tlcsc_pf_gap

// ===== tlcsc_pkg.sv
// types shared by the two-level cache state controller
`include "tlcsc_regs.svh"

package tlcsc_pkg;

    typedef enum logic [1:0] {
        MESI_I = 2'b00,
        MESI_S = 2'b01,
        MESI_E = 2'b10,
        MESI_M = 2'b11
    } tlcsc_mesi_t;

    typedef enum logic [1:0] {
        OP_NONE  = 2'b00,
        OP_READ  = 2'b01,
        OP_WRITE = 2'b10
    } tlcsc_op_t;

    // one processor access, as presented by the core
    typedef struct packed {
        logic                         write;
        logic                         icache;
        logic                         sw_prefetch;
        logic                         cacheable;
        logic                         write_alloc;
        logic                         page_writethrough_attr;
        logic                         hw_pf_en;
        logic [`TLCSC_LINE_AW-1:0]    line;
    } tlcsc_req_t;

    // new tag states for one line
    typedef struct packed {
        tlcsc_mesi_t                  l1;
        tlcsc_mesi_t                  l2;
        logic [`TLCSC_LINE_AW-1:0]    line;
    } tlcsc_upd_t;

    // what an access does on the bus and to the tags
    typedef struct packed {
        tlcsc_op_t                    op;
        logic                         cacheable;
        logic                         post_wr;
        tlcsc_mesi_t                  l1;
        tlcsc_mesi_t                  l2;
    } tlcsc_plan_t;

endpackage

// ===== tlcsc_regs.svh
// constants of the two-level cache state controller
`ifndef TLCSC_REGS_SVH
`define TLCSC_REGS_SVH

// line address is the byte address without the 32-byte offset
`define TLCSC_LINE_AW      27
// the line-select bit inside a two-line sector
`define TLCSC_SECTOR_BIT   0
// reset values of the control state
`define TLCSC_RST_READY    1'b1
`define TLCSC_RST_KEN      1'b0
`define TLCSC_RST_WBS      1'b0

`endif

// ===== tlcsc_state_table.sv
// mesi transition table for processor reads and writes
`timescale 1ns/1ps

module tlcsc_state_table (
    input  wire tlcsc_pkg::tlcsc_req_t  req_in,    // access being served
    input  wire tlcsc_pkg::tlcsc_mesi_t l1_in,     // l1 state before
    input  wire tlcsc_pkg::tlcsc_mesi_t l2_in,     // l2 state before
    input  wire logic                   ken_in,    // line fill granted
    input  wire logic                   wb_in,     // writeback mode chosen
    output tlcsc_pkg::tlcsc_plan_t      plan_out   // bus op and new states
);
    // ------------------------------------------------------------------
    // derived states
    // ------------------------------------------------------------------
    wire tlcsc_pkg::tlcsc_mesi_t wb_state;
    wire tlcsc_pkg::tlcsc_mesi_t fill_state;
    wire                         l1_inv;
    wire                         l2_inv;

    assign wb_state   = wb_in ? tlcsc_pkg::MESI_E : tlcsc_pkg::MESI_S;
    assign fill_state = ken_in ? wb_state : tlcsc_pkg::MESI_I;
    assign l1_inv     = (l1_in == tlcsc_pkg::MESI_I);
    assign l2_inv     = (l2_in == tlcsc_pkg::MESI_I);

    // ------------------------------------------------------------------
    // table
    // ------------------------------------------------------------------
    always_comb begin
        plan_out = '{op: tlcsc_pkg::OP_NONE, cacheable: 1'b0,
                     post_wr: 1'b0, l1: l1_in, l2: l2_in};
        if (!req_in.write) begin
            if (l1_inv && l2_inv) begin
                plan_out.op        = tlcsc_pkg::OP_READ;
                plan_out.cacheable = req_in.cacheable;
                plan_out.l1        = fill_state;
                plan_out.l2        = fill_state;
            end else if (l1_inv && l2_in == tlcsc_pkg::MESI_M) begin
                // instruction side keeps l2 dirty, data side takes it
                plan_out.l1 = req_in.icache ? tlcsc_pkg::MESI_E
                                            : tlcsc_pkg::MESI_M;
                plan_out.l2 = req_in.icache ? tlcsc_pkg::MESI_M
                                            : tlcsc_pkg::MESI_E;
            end else if (l1_inv) begin
                plan_out.l1 = l2_in;
            end
        end else if (l1_inv && l2_inv) begin
            if (req_in.write_alloc) begin
                plan_out.op        = tlcsc_pkg::OP_READ;
                plan_out.cacheable = req_in.cacheable;
                plan_out.post_wr   = !(ken_in && wb_in);
                plan_out.l1        = (ken_in && wb_in) ? tlcsc_pkg::MESI_M
                                                       : fill_state;
                plan_out.l2        = fill_state;
            end else begin
                plan_out.op = tlcsc_pkg::OP_WRITE;
            end
        end else if (l1_in == tlcsc_pkg::MESI_S) begin
            plan_out.op = tlcsc_pkg::OP_WRITE;
            plan_out.l1 = wb_state;
            plan_out.l2 = l2_inv ? tlcsc_pkg::MESI_I : wb_state;
        end else if (!l1_inv) begin
            plan_out.l1 = tlcsc_pkg::MESI_M;
        end else if (l2_in == tlcsc_pkg::MESI_S) begin
            plan_out.op = tlcsc_pkg::OP_WRITE;
            plan_out.l2 = wb_state;
            plan_out.l1 = req_in.write_alloc ? wb_state : tlcsc_pkg::MESI_I;
        end else if (req_in.write_alloc) begin
            plan_out.l1 = tlcsc_pkg::MESI_M;
            plan_out.l2 = tlcsc_pkg::MESI_E;
        end else begin
            plan_out.l2 = tlcsc_pkg::MESI_M;
        end
    end

endmodule // tlcsc_state_table
